// file: core/gst_pkg.sv
// Purpose: shared constants and types for the gated sixteen-bit timer
// Assumes: classic wishbone slave, 32-bit data, one register per word
// Notes: printed offsets are not multiples of four, so they are indices
package gst_pkg;
    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_COUNT_LOW = 10'h312;
    localparam logic [9:0] IDX_COUNT_HIGH = 10'h313;
    localparam logic [9:0] IDX_CONTROL = 10'h314;
    localparam logic [9:0] IDX_GATE_CONTROL = 10'h315;
    localparam logic [9:0] IDX_CLOCK_SELECT = 10'h317;
    localparam logic [9:0] IDX_SYSTEM = 10'h318;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_W = 12;
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CON_ON = 0;
    localparam int CON_WIDE = 1;
    localparam int CON_NOSYNC = 2;
    localparam int CON_PS_LO = 4;
    localparam int GC_LEVEL = 2;
    localparam int GC_GO = 3;
    localparam int GC_SPM = 4;
    localparam int GC_TGM = 5;
    localparam int GC_POL = 6;
    localparam int GC_EN = 7;
    // system register bits
    localparam int SYS_OVF_FLAG = 0;
    localparam int SYS_OVF_EN = 1;
    localparam int SYS_GATE_FLAG = 2;
    localparam int SYS_GLOBAL_EN = 3;
    localparam int SYS_DISABLE = 4;
    // ------------------------------------------------------------
    // reset values and clock codes
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] GATE_RESET = 8'h00;
    localparam logic [4:0] CLK_SEL_RESET = 5'h00;
    localparam logic [4:0] CLK_SYS = 5'h02;
    localparam logic [4:0] CLK_SYS_QUARTER = 5'h01;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [2:0] QUARTER_LAST = 3'h3;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADDR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } gst_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } gst_wb_rsp_t;
endpackage

// file: core/gst_timer.sv
// Purpose: gated sixteen-bit up-counter with prescaler and compare hooks
// Assumes: sys_clk_i 10 MHz, external count and gate pins asynchronous
// Notes: single clock, external edges are detected after synchronisers
// Behaviour
// [R1] count up through sixteen bits, wrap to zero, set overflow flag
// [R2] overflow request needs timer on, overflow enable and global enable
// [R3] software clears the overflow flag in its service routine
// [R4] software clears counter and flag before enabling the interrupt
// [R5] sleep counting only unsynchronised and not on system clock or quarter
// [R6] overflow with enable set wakes the device from sleep
// [R7] current count is offered to capture units on capture event
// [R8] compare unit event when its value equals the current count
// [R9] special trigger clears counter without setting overflow flag
// [R10] counter write in same cycle as trigger wins over the clear
// [R11] software uses synchronised quarter clock for the special trigger
// [R12] module disable bit holds timer in reset, clock disconnected
// [R13] prescaler bits 5:4 divide by 1, 2, 4 or 8
// [R14] control bit 2 bypasses synchronisation, ignored for system clocks; here ext edges stay synchronised, bit only allows sleep counting
// [R15] control bit 1 selects sixteen-bit access versus two byte accesses
// [R16] bit 0 switches timer on, gate bit 7 makes gate qualify counting
// [R17] gate bit 6 selects active high or active low gate
// [R18] gate bit 5 toggles flip-flop on rising gate edges, else held clear
// [R19] gate bit 4 enables single-pulse mode controlling the gate
// [R20] go bit arms on next edge, self-clears on pulse trailing edge
// [R21] clearing single-pulse mode clears the go bit at once
// [R22] gate level bit readable always, its fall sets gate event flag
// [R23] wide mode: low read latches high, low write loads buffered high
// [R24] overflow flag set on the wrapping count, held until cleared
`timescale 1ns/1ns
module gst_timer
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire gst_pkg::gst_wb_req_t wb_req_i,
    output gst_pkg::gst_wb_rsp_t wb_rsp_o,
    input wire logic ext_clk_i,
    input wire logic gate_i,
    input wire logic sleep_i,
    input wire logic special_trigger_i,
    input wire logic [15:0] compare_value_i,
    output logic [15:0] count_value_o,
    output logic compare_match_o,
    output logic overflow_irq_o,
    output logic wake_o
);
    import gst_pkg::*;

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [7:0] timer_control;
    logic [7:0] timer_gate_control;
    logic [4:0] clock_source_select;
    logic [15:0] count_value;
    logic [7:0] high_buffer;
    logic overflow_irq_flag;
    logic overflow_irq_enable;
    logic gate_event_irq_flag;
    logic global_irq_enable;
    logic module_disable_bit;
    logic ack;
    logic [31:0] rd_data;
    logic [1:0] ext_sync;
    logic [1:0] gate_sync;
    logic ext_prev;
    logic gate_prev;
    logic level_prev;
    logic [1:0] quarter;
    logic [2:0] prescale_cnt;
    logic toggle_ff;
    logic pulse_acquire_go;
    logic pulse_armed;
    logic blk_reset;

    assign blk_reset = reset_i | module_disable_bit; // R12

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr;
    logic rd;
    logic [9:0] idx;
    assign req = wb_req_i.cyc & wb_req_i.stb & ~ack;
    assign wr = req & wb_req_i.we & wb_req_i.sel[0];
    assign rd = req & ~wb_req_i.we;
    assign idx = wb_req_i.adr[ADDR_W-1:ADDR_LSB];
    logic wr_low;
    logic wr_high;
    logic wr_con;
    logic wr_gcon;
    logic wr_sys;
    logic rd_low;
    assign wr_low = wr & (idx == IDX_COUNT_LOW);
    assign wr_high = wr & (idx == IDX_COUNT_HIGH);
    assign wr_con = wr & (idx == IDX_CONTROL);
    assign wr_gcon = wr & (idx == IDX_GATE_CONTROL);
    assign wr_sys = wr & (idx == IDX_SYSTEM);
    assign rd_low = rd & (idx == IDX_COUNT_LOW);
    logic [7:0] wdat;
    assign wdat = wb_req_i.dat[7:0];

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            ack <= 1'b0;
        else
            ack <= req;
    end

    // ------------------------------------------------------------
    // input synchronisers and clock selection
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            ext_sync <= 2'b00;
            gate_sync <= 2'b00;
            ext_prev <= 1'b0;
            gate_prev <= 1'b0;
        end
        else
        begin
            ext_sync <= {ext_sync[0], ext_clk_i};
            gate_sync <= {gate_sync[0], gate_i};
            ext_prev <= ext_sync[1];
            gate_prev <= gate_sync[1];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (blk_reset)
            quarter <= 2'b00;
        else
            quarter <= quarter + 2'b01;
    end

    logic sys_src;
    logic raw_tick;
    logic ext_rise;
    assign sys_src = (clock_source_select == CLK_SYS)
        | (clock_source_select == CLK_SYS_QUARTER);
    assign ext_rise = ext_sync[1] & ~ext_prev;
    always_comb
    begin
        if (clock_source_select == CLK_SYS)
            raw_tick = 1'b1;
        else if (clock_source_select == CLK_SYS_QUARTER)
            raw_tick = ({1'b0, quarter} == QUARTER_LAST);
        else
            raw_tick = ext_rise;
    end

    // sleep stops system-derived and synchronised counting
    logic sleep_ok;
    assign sleep_ok = ~sleep_i
        | (~sys_src & timer_control[CON_NOSYNC]); // R5 R14

    // ------------------------------------------------------------
    // gate path
    // ------------------------------------------------------------
    logic gate_pol;
    logic gate_rise;
    logic gate_level;
    assign gate_pol = gate_sync[1] ~^ timer_gate_control[GC_POL]; // R17
    assign gate_rise = gate_sync[1] & ~gate_prev;

    always_ff @(posedge sys_clk_i)
    begin
        if (blk_reset | ~timer_gate_control[GC_TGM])
            toggle_ff <= 1'b0; // R18
        else if (gate_rise)
            toggle_ff <= ~toggle_ff; // R18
    end

    logic gate_pre;
    assign gate_pre = timer_gate_control[GC_TGM] ? toggle_ff : gate_pol;

    always_ff @(posedge sys_clk_i)
    begin
        if (blk_reset)
            level_prev <= 1'b0;
        else
            level_prev <= gate_pre;
    end

    // single-pulse: go arms, pulse passes once, trailing edge clears go
    always_ff @(posedge sys_clk_i)
    begin
        if (blk_reset)
        begin
            pulse_acquire_go <= 1'b0;
            pulse_armed <= 1'b0;
        end
        else if (~timer_gate_control[GC_SPM] | (wr_gcon & ~wdat[GC_SPM]))
        begin
            pulse_acquire_go <= 1'b0; // R21
            pulse_armed <= 1'b0;
        end
        else if (pulse_acquire_go & pulse_armed & level_prev & ~gate_pre)
        begin
            pulse_acquire_go <= 1'b0; // R20
            pulse_armed <= 1'b0;
        end
        else if (wr_gcon & ~wdat[GC_GO] & wdat[GC_SPM])
            pulse_acquire_go <= 1'b0;
        else if (wr_gcon & wdat[GC_GO] & wdat[GC_SPM])
            pulse_acquire_go <= 1'b1;
        else if (pulse_acquire_go & gate_pre & ~level_prev)
            pulse_armed <= 1'b1; // R20
    end

    assign gate_level = timer_gate_control[GC_SPM]
        ? (pulse_armed & gate_pre) : gate_pre; // R19

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic timer_on;
    logic gate_ok;
    logic count_en;
    logic [2:0] ps_limit;
    logic ps_tick;
    assign timer_on = timer_control[CON_ON];
    assign gate_ok = ~timer_gate_control[GC_EN] | gate_level; // R16
    assign count_en = timer_on & gate_ok & sleep_ok & raw_tick;
    assign ps_limit = 3'((4'h1 << timer_control[CON_PS_LO +: 2]) - 4'h1);
    assign ps_tick = count_en & (prescale_cnt == ps_limit); // R13

    always_ff @(posedge sys_clk_i)
    begin
        if (blk_reset | wr_low)
            prescale_cnt <= 3'h0;
        else if (count_en)
            prescale_cnt <= ps_tick ? 3'h0 : prescale_cnt + 3'h1; // R13
    end

    // ------------------------------------------------------------
    // counter and wide-access buffer
    // ------------------------------------------------------------
    logic wrap;
    assign wrap = ps_tick & (count_value == COUNT_MAX);

    always_ff @(posedge sys_clk_i)
    begin
        if (blk_reset)
            count_value <= COUNT_ZERO;
        else if (wr_low & timer_control[CON_WIDE])
            count_value <= {high_buffer, wdat}; // R23 R10
        else if (wr_low)
            count_value[7:0] <= wdat; // R15 R10
        else if (wr_high & ~timer_control[CON_WIDE])
            count_value[15:8] <= wdat; // R15 R10
        else if (special_trigger_i)
            count_value <= COUNT_ZERO; // R9
        else if (ps_tick)
            count_value <= count_value + 16'h0001; // R1
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (blk_reset)
            high_buffer <= 8'h00;
        else if (rd_low & timer_control[CON_WIDE])
            high_buffer <= count_value[15:8]; // R23
        else if (wr_high & timer_control[CON_WIDE])
            high_buffer <= wdat; // R23
    end

    // ------------------------------------------------------------
    // software registers and flags
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (blk_reset)
        begin
            timer_control <= CONTROL_RESET;
            timer_gate_control <= GATE_RESET;
            clock_source_select <= CLK_SEL_RESET;
            overflow_irq_enable <= 1'b0;
            global_irq_enable <= 1'b0;
        end
        else
        begin
            if (wr_con)
                timer_control <= wdat;
            if (wr_gcon)
                timer_gate_control <= wdat;
            if (wr & (idx == IDX_CLOCK_SELECT))
                clock_source_select <= wdat[4:0];
            if (wr_sys)
            begin
                overflow_irq_enable <= wdat[SYS_OVF_EN];
                global_irq_enable <= wdat[SYS_GLOBAL_EN];
            end
        end
    end

    // disable bit lives outside the held reset so software can clear it
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            module_disable_bit <= 1'b0;
        else if (wr_sys)
            module_disable_bit <= wdat[SYS_DISABLE]; // R12
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge sys_clk_i)
    begin
        if (blk_reset)
        begin
            overflow_irq_flag <= 1'b0;
            gate_event_irq_flag <= 1'b0;
        end
        else
        begin
            if (wrap & ~special_trigger_i & ~wr_low
                & ~(wr_high & ~timer_control[CON_WIDE]))
                overflow_irq_flag <= 1'b1; // R24 R1
            else if (wr_sys & ~wdat[SYS_OVF_FLAG])
                overflow_irq_flag <= 1'b0; // R3
            if (level_prev & ~gate_level)
                gate_event_irq_flag <= 1'b1; // R22
            else if (wr_sys & ~wdat[SYS_GATE_FLAG])
                gate_event_irq_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [7:0] gcon_rd;
    assign gcon_rd = {timer_gate_control[7:4], pulse_acquire_go,
        gate_level, 2'b00}; // R22
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            rd_data <= 32'h0000_0000;
        else if (rd)
        begin
            unique case (idx)
                IDX_COUNT_LOW: rd_data <= {24'h0, count_value[7:0]};
                IDX_COUNT_HIGH: rd_data <= {24'h0, timer_control[CON_WIDE]
                    ? high_buffer : count_value[15:8]}; // R23 R15
                IDX_CONTROL: rd_data <= {24'h0, timer_control};
                IDX_GATE_CONTROL: rd_data <= {24'h0, gcon_rd};
                IDX_CLOCK_SELECT: rd_data <= {27'h0, clock_source_select};
                IDX_SYSTEM: rd_data <= {27'h0, module_disable_bit,
                    global_irq_enable, gate_event_irq_flag,
                    overflow_irq_enable, overflow_irq_flag};
                default: rd_data <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_rsp_o.ack = ack;
    assign wb_rsp_o.dat = rd_data;
    assign count_value_o = count_value; // R7
    assign compare_match_o = (compare_value_i == count_value); // R8
    assign overflow_irq_o = overflow_irq_flag & timer_on
        & overflow_irq_enable & global_irq_enable; // R2
    assign wake_o = sleep_i & overflow_irq_flag
        & overflow_irq_enable; // R6

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_wrap_sets_flag: assert property (@(posedge sys_clk_i) // R24
        disable iff (blk_reset)
        wrap & ~special_trigger_i & ~wr_low & ~wr_high
        |=> overflow_irq_flag & count_value == COUNT_ZERO)
        else $error("wrap did not set overflow flag");
    a_trigger_clears: assert property (@(posedge sys_clk_i) // R9
        disable iff (blk_reset)
        special_trigger_i & ~wr_low & ~wr_high & ~overflow_irq_flag
        |=> count_value == COUNT_ZERO & ~overflow_irq_flag)
        else $error("trigger clear wrong");
    a_write_wins: assert property (@(posedge sys_clk_i) // R10
        disable iff (blk_reset)
        wr_low & ~timer_control[CON_WIDE] & special_trigger_i
        |=> count_value[7:0] == $past(wdat))
        else $error("write lost to trigger");
    a_irq_gating: assert property (@(posedge sys_clk_i) // R2
        disable iff (blk_reset)
        overflow_irq_o |-> timer_on & overflow_irq_enable)
        else $error("irq without enables");
    a_spm_clears_go: assert property (@(posedge sys_clk_i) // R21
        disable iff (blk_reset)
        $fell(timer_gate_control[GC_SPM]) |-> ~pulse_acquire_go)
        else $error("go survived mode clear");
    a_toggle_held: assert property (@(posedge sys_clk_i) // R18
        disable iff (blk_reset)
        ~timer_gate_control[GC_TGM] [*2] |-> ~toggle_ff)
        else $error("toggle not held clear");
    a_gate_fall_flag: assert property (@(posedge sys_clk_i) // R22
        disable iff (blk_reset)
        level_prev & ~gate_level |=> gate_event_irq_flag)
        else $error("gate fall missed");
    a_off_holds: assert property (@(posedge sys_clk_i) // R16
        disable iff (blk_reset)
        ~timer_on & ~wr_low & ~wr_high & ~special_trigger_i
        |=> $stable(count_value))
        else $error("counted while off");
    a_div8_spacing: assert property (@(posedge sys_clk_i) // R13
        disable iff (blk_reset)
        ps_tick & timer_control[CON_PS_LO +: 2] == 2'b11
        & clock_source_select == CLK_SYS & ~wr_con & ~wr_low
        |=> ~ps_tick [*7])
        else $error("prescale by 8 wrong");
endmodule

// file: sim/gst_partner.sv
// Purpose: compare unit model facing the timer's time base outputs
// Assumes: same clock as the timer, trigger is a one-cycle pulse
// Notes: counts how many special triggers it has sent
`timescale 1ns/1ns
module gst_partner
#(
    parameter logic [15:0] PERIOD = 16'h0010
)
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic compare_match_i,
    output logic special_trigger_o,
    output logic [15:0] compare_value_o,
    output logic [15:0] fired_count_o
);
    // ------------------------------------------------------------
    // compare register acts as the period value
    // ------------------------------------------------------------
    assign compare_value_o = PERIOD;
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            special_trigger_o <= 1'b0;
            fired_count_o <= 16'h0000;
        end
        else
        begin
            // one pulse for each match while enabled
            special_trigger_o <= enable_i & compare_match_i
                & ~special_trigger_o;
            if (special_trigger_o)
                fired_count_o <= fired_count_o + 16'h0001;
        end
    end
endmodule

// file: sim/gst_timer_tb_top.sv
// Purpose: self-checking bench for the gated sixteen-bit timer
// Assumes: classic wishbone master, 10 MHz clock
// Notes: external count pin stays low, sleep driven by the overflow test
`timescale 1ns/1ns
module gst_timer_tb_top;
    import gst_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    gst_wb_req_t req = '0;
    gst_wb_rsp_t rsp;
    logic gate = 1'b0;
    logic sleep = 1'b0;
    logic trig_en = 1'b0;
    logic trig;
    logic [15:0] cmp_val, count, fired;
    logic match, irq, wake;
    int bad_count = 0;
    int checks_done = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    gst_timer i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .wb_req_i(req), .wb_rsp_o(rsp), .ext_clk_i(1'b0), .gate_i(gate),
        .sleep_i(sleep), .special_trigger_i(trig),
        .compare_value_i(cmp_val), .count_value_o(count),
        .compare_match_o(match), .overflow_irq_o(irq), .wake_o(wake));
    gst_partner i_partner (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .enable_i(trig_en), .compare_match_i(match),
        .special_trigger_o(trig), .compare_value_o(cmp_val),
        .fired_count_o(fired));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wb_cycle(input logic [9:0] idx, input logic wr,
        input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: wr, adr: {idx, 2'b00},
            sel: 4'h1, dat: {24'h000000, d}};
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (rsp.ack !== 1'b1 && n < 50);
        q = rsp.dat;
        if (n >= 50)
            check(32'h0, 32'h1);
        req <= '0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb_cycle(idx, 1'b1, d, q);
    endtask
    task automatic rd(input logic [9:0] idx, output logic [31:0] q);
        wb_cycle(idx, 1'b0, 8'h00, q);
    endtask
    task automatic delta(input int cyc, output logic [15:0] d);
        logic [15:0] a;
        @(negedge sys_clk_i);
        a = count;
        repeat (cyc) @(negedge sys_clk_i);
        d = count - a;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        logic [31:0] q;
        rd(IDX_CONTROL, q);
        check(q, 32'h00);
        rd(IDX_GATE_CONTROL, q);
        check(q & 32'hF8, 32'h00);
        rd(10'h100, q);
        check(q, 32'h0);
        check(count, 32'h0);
        $display("test reset_values done");
    endtask
    task automatic t_prescale;
        logic [15:0] d;
        wr(IDX_CLOCK_SELECT, 8'h02);
        for (int ps = 0; ps < 4; ps++)
        begin
            wr(IDX_CONTROL, 8'h01 | 8'(ps << CON_PS_LO));
            delta(4 << ps, d);
            check(d, 32'd4);
        end
        wr(IDX_CONTROL, 8'h00);
        $display("test prescale done");
    endtask
    task automatic t_overflow;
        logic [31:0] q;
        logic [15:0] d;
        int n;
        wr(IDX_SYSTEM, 8'h0A);
        wr(IDX_CONTROL, 8'h02);
        wr(IDX_COUNT_HIGH, 8'hFF);
        wr(IDX_COUNT_LOW, 8'hF0);
        check(count, 32'hFFF0);
        check(irq, 32'h0);
        wr(IDX_CONTROL, 8'h03);
        n = 0;
        do
        begin
            @(negedge sys_clk_i);
            n++;
        end
        while (irq !== 1'b1 && n < 100);
        check(count, 32'h0);
        wr(IDX_SYSTEM, 8'h03);
        check(irq, 32'h0);
        @(posedge sys_clk_i);
        sleep <= 1'b1;
        delta(4, d);
        check(d, 32'h0);
        check(wake, 32'h1);
        @(posedge sys_clk_i);
        sleep <= 1'b0;
        @(posedge sys_clk_i);
        check(wake, 32'h0);
        rd(IDX_SYSTEM, q);
        check(q[SYS_OVF_FLAG], 32'h1);
        wr(IDX_SYSTEM, 8'h0A);
        rd(IDX_SYSTEM, q);
        check(q[SYS_OVF_FLAG], 32'h0);
        wr(IDX_CONTROL, 8'h00);
        $display("test overflow done");
    endtask
    task automatic t_trigger;
        logic [31:0] q;
        logic [15:0] top;
        top = 16'h0000;
        wr(IDX_COUNT_LOW, 8'h00);
        wr(IDX_COUNT_HIGH, 8'h00);
        wr(IDX_SYSTEM, 8'h02);
        wr(IDX_CLOCK_SELECT, 8'h01);
        trig_en <= 1'b1;
        wr(IDX_CONTROL, 8'h01);
        repeat (300)
        begin
            @(negedge sys_clk_i);
            if (count > top)
                top = count;
        end
        check(top, 32'h0010);
        check(fired == 16'h0000, 32'h0);
        rd(IDX_SYSTEM, q);
        check(q[SYS_OVF_FLAG], 32'h0);
        trig_en <= 1'b0;
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_CLOCK_SELECT, 8'h02);
        $display("test trigger done");
    endtask
    task automatic t_gate;
        logic [15:0] d;
        logic [31:0] q;
        wr(IDX_GATE_CONTROL, 8'hC0);
        wr(IDX_CONTROL, 8'h01);
        delta(10, d);
        check(d, 32'h0);
        @(posedge sys_clk_i);
        gate <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        delta(10, d);
        check(d, 32'd10);
        rd(IDX_GATE_CONTROL, q);
        check(q[GC_LEVEL], 32'h1);
        wr(IDX_GATE_CONTROL, 8'h80);
        delta(10, d);
        check(d, 32'h0);
        wr(IDX_GATE_CONTROL, 8'h00);
        delta(10, d);
        check(d, 32'd10);
        @(posedge sys_clk_i);
        gate <= 1'b0;
        $display("test gate done");
    endtask
    task automatic t_disable;
        logic [31:0] q;
        wr(IDX_SYSTEM, 8'h10);
        rd(IDX_CONTROL, q);
        check(q, 32'h00);
        check(count, 32'h0);
        wr(IDX_SYSTEM, 8'h00);
        rd(IDX_CONTROL, q);
        check(q, 32'h00);
        $display("test disable done");
    endtask
    // ------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        bad_count++;
        give_verdict();
    end
    initial
    begin
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        t_reset_values();
        t_prescale();
        t_overflow();
        t_trigger();
        t_gate();
        t_disable();
        give_verdict();
    end
endmodule
